/* bench/mcf_sink.sv */
// Purpose: byte sink model at the transmit side
// Assumes: byte taken at an edge with valid and ready high
// Notes: stalls at random while slow_i is high
`timescale 1ns/100ps
module mcf_sink (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic slow_i,
    input wire logic [7:0] byte_i,
    input wire logic valid_i,
    input wire logic [1:0] dest_i,
    output logic ready_o
);
    logic [9:0] got[$];
    always @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ready_o <= 1'b0;
        end else begin
            if (valid_i && ready_o) begin
                got.push_back({dest_i, byte_i});
            end
            ready_o <= !slow_i || ($urandom % 3 != 0);
        end
    end
endmodule : mcf_sink

/* bench/multi_scale_cont_out_framer_test.sv */
// Purpose: self-checking bench for the frame builder
// Assumes: TICK_CYC shortened to 20
// Notes: frames checked byte by byte at the sink
`timescale 1ns/100ps
module multi_scale_cont_out_framer_test import mcf_pkg::*;;
    logic clk_sys_i = 0;
    logic arst_n_i = 0;
    logic [7:0] reg_addr_i, tx_byte_o;
    logic [31:0] reg_wdata_i, reg_rdata_o, r;
    logic reg_wr_i, reg_rd_i, net_login_i, tx_ready_i, tx_valid_o, slow;
    logic [1:0] tx_dest_o;
    mcf_scale_t [NUM_CH-1:0] scale_i;
    int num_errors = 0;
    int checks_done = 0;
    always #25 clk_sys_i = ~clk_sys_i;
    mcf_framer #(.TICK_CYC(20)) i_dut (.clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .scale_i(scale_i), .net_login_i(net_login_i),
        .tx_ready_i(tx_ready_i), .tx_byte_o(tx_byte_o),
        .tx_valid_o(tx_valid_o), .tx_dest_o(tx_dest_o));
    mcf_sink i_sink (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
        .slow_i(slow), .byte_i(tx_byte_o), .valid_i(tx_valid_o),
        .dest_i(tx_dest_o), .ready_o(tx_ready_i));
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask : rd
    function automatic logic [7:0] fb(int ch, int k, bit v2);
        mcf_scale_t s = scale_i[ch];
        bit lz = 1;
        if (k == 0) return v2 ? 8'h02 : 8'(ch + 1);
        if (k == 1) return {3'b001, s.build, s.dp};
        if (k == 2) return {1'b0, s.pwr, 1'b1, s.kg, s.motion, s.oor,
            s.neg, s.net};
        if (k == 3) return {3'b001, s.expand, s.print,
            v2 ? 3'(ch + 1) : 3'h0};
        if (k == 16) return 8'h0D;
        if (k >= 10) return 8'h30 + 8'(s.tare[15 - k]);
        for (int i = 5; i >= 9 - k; i--) lz &= (s.wt[i] == 4'h0);
        return (lz && k < 9) ? 8'h20 : 8'h30 + 8'(s.wt[9 - k]);
    endfunction : fb
    function automatic logic [7:0] hb(int k, int sq, bit ack);
        if (k == 2) return ack ? 8'h47 : 8'h43;
        if (k == 3) return 8'h30 + 8'(sq / 100);
        if (k == 4) return 8'h30 + 8'(sq / 10 % 10);
        if (k == 5) return 8'h30 + 8'(sq % 10);
        if (k == 6) return 8'h7E;
        if (k == 7) return 8'h31;
        return (k == 8) ? 8'h0D : 8'h30;
    endfunction : hb
    task automatic wait_got(int n);
        for (int i = 0; i < 20000 && i_sink.got.size() < n; i++)
            @(posedge clk_sys_i);
        check("byte count", 32'(i_sink.got.size() >= n), 32'h1);
    endtask : wait_got
    task automatic run_tmpl(int len);
        logic [7:0] t[$];
        wr(REG_TADDR, 32'h0000_0200);
        for (int k = 0; k < len; k++) begin
            t.push_back(8'($urandom));
            wr(REG_TDATA, {24'h0, t[k]});
        end
        wr(REG_TLEN, 32'(len));
        i_sink.got.delete();
        wr(REG_CTRL, 32'h0000_2028);
        rd(REG_TLEN, r);
        check("template length", r, 32'(len));
        wait_got(2 * len);
        wr(REG_CTRL, 32'h0000_0028);
        for (int k = 0; k < 2 * len; k++)
            check("template byte", 32'(i_sink.got[k]),
                32'(t[k % len]));
        repeat (100) @(posedge clk_sys_i);
        wr(REG_TLEN, 32'h0000_00FF);
        rd(REG_TLEN, r);
        check("template clamp", r, TMPL_MAX);
        $display("test done template length %0d", len);
    endtask : run_tmpl
    task automatic run_case(bit v2, logic [1:0] conn, logic [4:0] mask);
        int ord[$];
        int n, ch, sum, flen;
        logic [7:0] b;
        logic [7:0] e[$];
        mcf_scale_t s;
        for (int c = 0; c < NUM_CH; c++) begin
            if (mask[c]) ord.push_back(c);
            s = mcf_scale_t'(61'({$urandom, $urandom}));
            s.build = 2'(1 + $urandom % 3);
            for (int d = 0; d < NUM_DIG; d++) begin
                s.wt[d] = 4'($urandom % 10);
                s.tare[d] = 4'($urandom % 10);
            end
            s.wt[0] = 4'(1 + $urandom % 9);
            if (c % 2 == 1) s.wt[5:4] = '0;
            scale_i[c] <= s;
        end
        flen = (conn == CONN_COM) ? 18 : 17;
        i_sink.got.delete();
        wr(REG_CTRL, {18'h0, 1'b1, mask, 4'h0, 1'b0, conn, v2});
        if (conn == CONN_NET) begin
            wr(REG_NETCMD, {30'h0, CMD_REG});
            for (int k = 0; k < 9; k++) e.push_back(hb(k, 1, 1));
        end
        for (int f = 0; f < 2 * ord.size(); f++) begin
            ch = ord[f % ord.size()];
            if (conn == CONN_NET && f % ord.size() == 0) begin
                for (int k = 0; k < 7; k++)
                    e.push_back(hb(k, 2 + f / ord.size(), 0));
            end
            sum = 0;
            for (int k = 0; k < flen; k++) begin
                b = (k == 17) ? {1'b0, 7'(-sum)} : fb(ch, k, v2);
                sum += b;
                e.push_back(b);
            end
        end
        wait_got(e.size());
        if (conn == CONN_NET) begin
            wr(REG_NETCMD, {30'h0, CMD_XGROUP});
            repeat (100) @(posedge clk_sys_i);
            n = i_sink.got.size();
            repeat (200) @(posedge clk_sys_i);
            check("sent after remove", 32'(i_sink.got.size()),
                32'(n));
        end
        wr(REG_CTRL, 32'h0);
        foreach (e[i])
            check("frame byte", 32'(i_sink.got[i]),
                {22'h0, conn, e[i]});
        repeat (300) @(posedge clk_sys_i);
        $display("test done variant %0d conn %0d mask %h", v2, conn, mask);
    endtask : run_case
    initial begin
        reg_addr_i = 0;
        reg_wdata_i = 0;
        reg_wr_i = 0;
        reg_rd_i = 0;
        net_login_i = 0;
        slow = 0;
        scale_i = '0;
        void'($urandom(14));
        repeat (20) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        rd(REG_STATUS, r);
        check("status", r, {15'h0, 12'h999, 5'h01});
        rd(8'h1C, r);
        check("unmapped", r, 32'h0);
        $display("test done registers");
        run_case(0, CONN_COM, 5'h11);
        slow = 1;
        run_case(0, CONN_COM, 5'h1F);
        run_case(1, CONN_COM, 5'h0A);
        run_case(1, CONN_EPRINT, 5'h13);
        run_case(0, CONN_EPRINT, 5'h04);
        run_tmpl(5 + $urandom % 20);
        net_login_i <= 1'b1;
        wr(REG_CTIMER, 32'h0000_0003);
        run_case(0, CONN_NET, 5'h04);
        give_verdict();
    end
    initial begin
        #1000000;
        num_errors++;
        give_verdict();
    end
endmodule : multi_scale_cont_out_framer_test

/* core/mcf_framer.sv */
// Purpose: multi-scale continuous output frame builder
// Assumes: inputs come from logic on clk_sys_i
// Notes: one byte per handshake on tx_byte_o/tx_valid_o/tx_ready_i
// Function
// - variant 1 sends one frame per enabled scale, channel code leads
// - variant 1 lead code is 01 to 04 for scales, 05 for sum
// - frame order: lead, A, B, C, six weight, six tare, CR, checksum
// - weight is six digits, leading zeros sent as spaces
// - tare is six digits, no sign or point
// - data ends with carriage return 0D before checksum
// - checksum is two's complement of low seven bits of byte sum
// - checksum only on serial port connections
// - variant 2 frames always lead with STX 02
// - variant 2 puts channel number in status C bits 0 to 2
// - status A: decimal code, build code, bit5 one, bit6 zero
// - status B: net, sign, range, motion, unit, power-up, bit5 one
// - status C: print bit3, expand bit4, bit5 one, bit6 zero
// - template mode uses one of ten templates, at most 200 chars
// - template output repeats back to back, paced by the sink
// - logged-in registered client gets a message per output
// - registration is acknowledged with the stream count
// - unregister or remove-all-groups stops client output
// - callback messages spaced by at least the timer interval
// - network print connection sends raw frames, no registration
// - header: status 00, type letter, sequence 001 to 999 wrapping
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/100ps
module mcf_framer import mcf_pkg::*; #(
    parameter int TICK_CYC = CLK_HZ / MS_PER_S * CTIMER_UNIT_MS
) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire mcf_scale_t [NUM_CH-1:0] scale_i,
    input wire logic net_login_i,
    input wire logic tx_ready_i,
    output logic [7:0] tx_byte_o,
    output logic tx_valid_o,
    output logic [1:0] tx_dest_o
);
    localparam int CTRL_W = $bits(mcf_ctrl_t);
    localparam int TADDR_W = $bits(mcf_taddr_t);

    mcf_state_t st_q, st_d;
    mcf_ctrl_t ctrl_q, ctrl_d;
    mcf_taddr_t taddr_q, taddr_d;
    mcf_scale_t fr_q, fr_d;
    logic [7:0] idx_q, idx_d;
    logic [CH_W-1:0] ch_q, ch_d;
    logic [6:0] sum_q, sum_d;
    logic [7:0] byte_q, byte_d;
    logic vld_q, vld_d;
    logic [1:0] dest_q, dest_d;
    logic [11:0] seq_q, seq_d;
    logic [15:0] ctimer_q, ctimer_d;
    logic [15:0] ms_q, ms_d;
    logic [15:0] pre_q, pre_d;
    logic reg_q, reg_d;
    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic [7:0] tlen_q [TMPL_NUM];
    logic [7:0] tmem [TMPL_NUM*TMPL_MAX];

    logic adv, load, has_data, gate_ok, last;
    logic [7:0] cur, tlen_sel, frm_last;
    logic [CH_W-1:0] ch_code;
    logic [CH_W:0] first_ch, nxt_ch;
    logic [7:0] wt_chr [NUM_DIG];
    logic [TMEM_AW-1:0] trd_addr, twr_addr;
    mcf_stat_t stat;

    function automatic logic [CH_W:0] next_en(logic [NUM_CH-1:0] en,
                                              int from);
        logic [CH_W:0] r;
        r = {1'b1, {CH_W{1'b0}}};
        for (int k = NUM_CH - 1; k >= 0; k--) begin
            if (k >= from && en[k]) begin
                r = {1'b0, CH_W'(k)};
            end
        end
        return r;
    endfunction : next_en

    function automatic logic [11:0] seq_next(logic [11:0] s);
        logic [11:0] r;
        logic c;
        r = s;
        c = 1'b1;
        if (s == SEQ_LAST) begin
            r = SEQ_FIRST;
        end else begin
            for (int k = 0; k < SEQ_DIGITS; k++) begin
                if (c) begin
                    if (r[k*4+:4] == BCD_MAX) begin
                        r[k*4+:4] = 4'h0;
                    end else begin
                        r[k*4+:4] = r[k*4+:4] + 4'h1;
                        c = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction : seq_next

    // byte of the current frame, header or template
    always_comb begin
        logic lz;
        lz = 1'b1;
        ch_code = ch_q + CH_CODE_OFS;
        for (int k = NUM_DIG - 1; k >= 0; k--) begin
            lz = lz & (fr_q.wt[k] == 4'h0);
            if (lz && k != 0) begin
                wt_chr[k] = CHR_SP;
            end else begin
                wt_chr[k] = CHR_ZERO | {4'h0, fr_q.wt[k]};
            end
        end
        trd_addr = TMEM_AW'(ctrl_q.tsel) * TMEM_AW'(TMPL_MAX)
            + TMEM_AW'(idx_q);
        cur = CHR_SP;
        if (st_q == ST_HDR || st_q == ST_ACK) begin
            if (idx_q == HPOS_TYPE) begin
                cur = (st_q == ST_ACK) ? CHR_TYPE_G : CHR_TYPE_C;
            end else if (idx_q >= HPOS_SEQ && idx_q < HPOS_TILDE) begin
                cur = CHR_ZERO
                    | {4'h0, seq_q[4*(HPOS_TILDE-idx_q-8'h01)+:4]};
            end else if (idx_q == HPOS_TILDE) begin
                cur = CHR_TILDE;
            end else if (idx_q == HPOS_CNT) begin
                cur = CHR_ZERO | {7'h00, reg_q};
            end else if (idx_q > HPOS_CNT) begin
                cur = CHR_CR;
            end else begin
                cur = CHR_ZERO;
            end
        end else if (st_q == ST_TPL) begin
            cur = tmem[trd_addr];
        end else if (st_q == ST_FRM) begin
            if (idx_q == POS_LEAD) begin
                cur = ctrl_q.variant2 ? CHR_STX
                    : {5'h00, ch_code};
            end else if (idx_q == POS_SWA) begin
                cur = mcf_swa_t'{1'b0, 1'b0, 1'b1, fr_q.build,
                                 fr_q.dp};
            end else if (idx_q == POS_SWB) begin
                cur = mcf_swb_t'{1'b0, fr_q.pwr, 1'b1, fr_q.kg,
                                 fr_q.motion, fr_q.oor, fr_q.neg,
                                 fr_q.net};
            end else if (idx_q == POS_SWC) begin
                cur = mcf_swc_t'{1'b0, 1'b0, 1'b1, fr_q.expand, fr_q.print,
                    ctrl_q.variant2 ? ch_code : 3'h0};
            end else if (idx_q < POS_TARE) begin
                cur = wt_chr[NUM_DIG-1-int'(idx_q-POS_WT)];
            end else if (idx_q < POS_CR) begin
                cur = CHR_ZERO
                    | {4'h0, fr_q.tare[NUM_DIG-1-int'(idx_q-POS_TARE)]};
            end else if (idx_q == POS_CR) begin
                cur = CHR_CR;
            end else begin
                cur = {1'b0, 7'(~sum_q + 7'h01)};
            end
        end
    end

    // sequencing, network session and register bus
    always_comb begin
        st_d = st_q;
        ctrl_d = ctrl_q;
        taddr_d = taddr_q;
        fr_d = fr_q;
        idx_d = idx_q;
        ch_d = ch_q;
        sum_d = sum_q;
        byte_d = byte_q;
        vld_d = vld_q;
        dest_d = dest_q;
        seq_d = seq_q;
        ctimer_d = ctimer_q;
        ms_d = ms_q;
        pre_d = pre_q;
        reg_d = reg_q;
        ack_d = ack_q;
        rdata_d = 32'h0000_0000;
        tlen_sel = (ctrl_q.tsel < 4'(TMPL_NUM)) ? tlen_q[ctrl_q.tsel]
            : 8'h00;
        has_data = ctrl_q.tmpl ? (tlen_sel != 8'h00)
            : (ctrl_q.en != '0);
        gate_ok = (ctrl_q.conn != CONN_NET)
            || (reg_q && ms_q == 16'h0000);
        frm_last = (ctrl_q.conn == CONN_COM) ? POS_CKS : POS_CR;
        first_ch = next_en(ctrl_q.en, 0);
        nxt_ch = next_en(ctrl_q.en, int'(ch_q) + 1);
        adv = !vld_q || tx_ready_i;
        load = 1'b0;
        last = 1'b0;
        stat = mcf_stat_t'{ack_q, reg_q, {1'b0, reg_q}, seq_q, st_q};
        if (vld_q && tx_ready_i) begin
            vld_d = 1'b0;
        end
        // callback spacing timer
        if (ms_q != 16'h0000) begin
            if (pre_q == 16'(TICK_CYC - 1)) begin
                pre_d = 16'h0000;
                ms_d = ms_q - 16'h0001;
            end else begin
                pre_d = pre_q + 16'h0001;
            end
        end
        unique case (st_q)
            ST_IDLE: begin
                if (ack_q) begin
                    st_d = ST_ACK;
                    idx_d = 8'h00;
                    seq_d = seq_next(seq_q);
                    ack_d = 1'b0;
                end else if (ctrl_q.run && has_data && gate_ok) begin
                    idx_d = 8'h00;
                    if (ctrl_q.conn == CONN_NET) begin
                        st_d = ST_HDR;
                        seq_d = seq_next(seq_q);
                        ms_d = ctimer_q;
                        pre_d = 16'h0000;
                    end else if (ctrl_q.tmpl) begin
                        st_d = ST_TPL;
                    end else begin
                        st_d = ST_FRM;
                        ch_d = first_ch[CH_W-1:0];
                        fr_d = scale_i[first_ch[CH_W-1:0]];
                    end
                end
            end
            ST_HDR, ST_ACK: begin
                load = adv;
                last = (idx_q == ((st_q == ST_ACK) ? ACK_LAST : HDR_LAST));
            end
            ST_FRM: begin
                load = adv;
                last = (idx_q == frm_last);
            end
            ST_TPL: begin
                load = adv;
                last = (idx_q == tlen_sel - 8'h01) || (tlen_sel == 8'h00);
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
        if (load) begin
            byte_d = cur;
            vld_d = 1'b1;
            dest_d = ctrl_q.conn;
            idx_d = idx_q + 8'h01;
            sum_d = ((idx_q == POS_LEAD) ? 7'h00 : sum_q) + cur[6:0];
            if (last) begin
                idx_d = 8'h00;
                st_d = ST_IDLE;
                if (st_q == ST_HDR && ctrl_q.tmpl) begin
                    st_d = ST_TPL;
                end else if (st_q == ST_HDR && !first_ch[CH_W]) begin
                    st_d = ST_FRM;
                    ch_d = first_ch[CH_W-1:0];
                    fr_d = scale_i[first_ch[CH_W-1:0]];
                end else if (st_q == ST_FRM && !nxt_ch[CH_W]) begin
                    st_d = ST_FRM;
                    ch_d = nxt_ch[CH_W-1:0];
                    fr_d = scale_i[nxt_ch[CH_W-1:0]];
                end
            end
        end
        // register writes
        if (reg_wr_i) begin
            if (reg_addr_i == REG_CTRL) begin
                ctrl_d = mcf_ctrl_t'(reg_wdata_i[CTRL_W-1:0]);
            end else if (reg_addr_i == REG_CTIMER) begin
                ctimer_d = reg_wdata_i[15:0];
            end else if (reg_addr_i == REG_TADDR) begin
                taddr_d = mcf_taddr_t'(reg_wdata_i[TADDR_W-1:0]);
            end else if (reg_addr_i == REG_TDATA) begin
                taddr_d.addr = taddr_q.addr + 8'h01;
            end else if (reg_addr_i == REG_NETCMD) begin
                if (reg_wdata_i[1:0] == CMD_REG && net_login_i) begin
                    reg_d = 1'b1;
                    ack_d = 1'b1;
                end else if (reg_wdata_i[1:0] == CMD_UNREG
                    || reg_wdata_i[1:0] == CMD_XGROUP) begin
                    reg_d = 1'b0;
                end
            end
        end
        if (!net_login_i) begin
            reg_d = 1'b0;
        end
        if (reg_rd_i) begin
            if (reg_addr_i == REG_CTRL) begin
                rdata_d = 32'(ctrl_q);
            end else if (reg_addr_i == REG_CTIMER) begin
                rdata_d = {16'h0000, ctimer_q};
            end else if (reg_addr_i == REG_TADDR) begin
                rdata_d = 32'(taddr_q);
            end else if (reg_addr_i == REG_TLEN) begin
                rdata_d = {24'h00_0000, tlen_sel};
            end else if (reg_addr_i == REG_STATUS) begin
                rdata_d = 32'(stat);
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_q <= ST_IDLE;
            ctrl_q <= '0;
            taddr_q <= '0;
            fr_q <= '0;
            idx_q <= 8'h00;
            ch_q <= '0;
            sum_q <= 7'h00;
            byte_q <= 8'h00;
            vld_q <= 1'b0;
            dest_q <= CONN_COM;
            seq_q <= SEQ_LAST;
            ctimer_q <= 16'h0000;
            ms_q <= 16'h0000;
            pre_q <= 16'h0000;
            reg_q <= 1'b0;
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            st_q <= st_d;
            ctrl_q <= ctrl_d;
            taddr_q <= taddr_d;
            fr_q <= fr_d;
            idx_q <= idx_d;
            ch_q <= ch_d;
            sum_q <= sum_d;
            byte_q <= byte_d;
            vld_q <= vld_d;
            dest_q <= dest_d;
            seq_q <= seq_d;
            ctimer_q <= ctimer_d;
            ms_q <= ms_d;
            pre_q <= pre_d;
            reg_q <= reg_d;
            ack_q <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    // template store and lengths
    assign twr_addr = TMEM_AW'(taddr_q.tnum) * TMEM_AW'(TMPL_MAX)
        + TMEM_AW'(taddr_q.addr);

    always_ff @(posedge clk_sys_i) begin
        if (reg_wr_i && reg_addr_i == REG_TDATA
            && taddr_q.tnum < 4'(TMPL_NUM) && taddr_q.addr < TMPL_MAX_B) begin
            tmem[twr_addr] <= reg_wdata_i[7:0];
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int k = 0; k < TMPL_NUM; k++) begin
                tlen_q[k] <= 8'h00;
            end
        end else if (reg_wr_i && reg_addr_i == REG_TLEN
            && taddr_q.tnum < 4'(TMPL_NUM)) begin
            tlen_q[taddr_q.tnum] <= (reg_wdata_i[7:0] > TMPL_MAX_B)
                ? TMPL_MAX_B : reg_wdata_i[7:0];
        end
    end

    assign tx_byte_o = byte_q;
    assign tx_valid_o = vld_q;
    assign tx_dest_o = dest_q;
    assign reg_rdata_o = rdata_q;

    // checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    lead_v1_a: assert property (
        load && st_q == ST_FRM && idx_q == POS_LEAD && !ctrl_q.variant2
        |=> tx_byte_o == {5'h00, $past(ch_q) + CH_CODE_OFS})
        else $error("variant 1 lead code wrong");
    lead_v2_a: assert property (
        load && st_q == ST_FRM && idx_q == POS_LEAD && ctrl_q.variant2
        |=> tx_byte_o == CHR_STX)
        else $error("variant 2 lead not STX");
    cr_pos_a: assert property (
        load && st_q == ST_FRM && idx_q == POS_CR
        |=> tx_valid_o && tx_byte_o == CHR_CR)
        else $error("carriage return missing");
    cks_value_a: assert property (
        load && st_q == ST_FRM && idx_q == POS_CKS
        |=> 7'(tx_byte_o[6:0] + $past(sum_q)) == 7'h00)
        else $error("checksum wrong");
    cks_port_a: assert property (
        st_q == ST_FRM && idx_q == POS_CKS |-> ctrl_q.conn == CONN_COM)
        else $error("checksum on non-serial connection");
    swc_chan_a: assert property (
        load && st_q == ST_FRM && idx_q == POS_SWC && ctrl_q.variant2
        |=> tx_byte_o[2:0] == $past(ch_q) + CH_CODE_OFS
            && tx_byte_o[6:5] == 2'b01)
        else $error("status C channel wrong");
    tmpl_len_a: assert property (
        st_q == ST_TPL |-> idx_q < TMPL_MAX_B)
        else $error("template overrun");
    net_reg_a: assert property (
        st_q == ST_HDR && $past(st_q) == ST_IDLE |-> $past(reg_q))
        else $error("callback without registration");
    unreg_a: assert property (
        reg_wr_i && reg_addr_i == REG_NETCMD
        && reg_wdata_i[1:0] == CMD_XGROUP
        |=> !reg_q ##1 (st_q != ST_HDR || $past(st_q) == ST_HDR))
        else $error("registration kept after remove");
    seq_range_a: assert property (
        (st_q == ST_HDR || st_q == ST_ACK) |-> seq_q != 12'h000
        && seq_q[3:0] <= BCD_MAX && seq_q[7:4] <= BCD_MAX
        && seq_q[11:8] <= BCD_MAX)
        else $error("sequence number out of range");
    ch_order_a: assert property (
        st_q == ST_FRM && $past(st_q) == ST_FRM && ch_q != $past(ch_q)
        |-> ch_q > $past(ch_q))
        else $error("channels out of order");
    spacing_a: assert property (
        st_q == ST_HDR && $past(st_q) == ST_IDLE |-> $past(ms_q) == 16'h0000)
        else $error("callback sent before interval");

    frame_cks_c: cover property (load && st_q == ST_FRM && idx_q == POS_CKS);
    tmpl_done_c: cover property (st_q == ST_TPL ##1 st_q == ST_IDLE);
    ack_sent_c: cover property (st_q == ST_ACK ##1 st_q == ST_IDLE);
    sum_ch_c: cover property (st_q == ST_FRM && ch_q == 3'h4);
endmodule : mcf_framer

/* core/mcf_pkg.sv */
// Purpose: shared constants and types for the multi-scale frame builder
// Assumes: 20 MHz system clock, byte-wide transmit sink
// Notes: status byte layouts are packed structs, msb first
package mcf_pkg;
    localparam int NUM_CH = 5;
    localparam int CH_W = 3;
    localparam int NUM_DIG = 6;
    localparam logic [CH_W-1:0] CH_CODE_OFS = 3'h1;
    localparam logic [7:0] CHR_STX = 8'h02;
    localparam logic [7:0] CHR_CR = 8'h0D;
    localparam logic [7:0] CHR_SP = 8'h20;
    localparam logic [7:0] CHR_ZERO = 8'h30;
    localparam logic [7:0] CHR_TILDE = 8'h7E;
    localparam logic [7:0] CHR_TYPE_C = 8'h43;
    localparam logic [7:0] CHR_TYPE_G = 8'h47;
    // byte positions inside a scale frame
    localparam logic [7:0] POS_LEAD = 8'h00;
    localparam logic [7:0] POS_SWA = 8'h01;
    localparam logic [7:0] POS_SWB = 8'h02;
    localparam logic [7:0] POS_SWC = 8'h03;
    localparam logic [7:0] POS_WT = 8'h04;
    localparam logic [7:0] POS_TARE = 8'h0A;
    localparam logic [7:0] POS_CR = 8'h10;
    localparam logic [7:0] POS_CKS = 8'h11;
    // byte positions inside a message header
    localparam logic [7:0] HPOS_TYPE = 8'h02;
    localparam logic [7:0] HPOS_SEQ = 8'h03;
    localparam logic [7:0] HPOS_TILDE = 8'h06;
    localparam logic [7:0] HPOS_CNT = 8'h07;
    localparam logic [7:0] HDR_LAST = 8'h06;
    localparam logic [7:0] ACK_LAST = 8'h08;
    localparam int SEQ_DIGITS = 3;
    localparam logic [3:0] BCD_MAX = 4'h9;
    localparam logic [11:0] SEQ_FIRST = 12'h001;
    localparam logic [11:0] SEQ_LAST = 12'h999;
    // templates
    localparam int TMPL_NUM = 10;
    localparam int TMPL_MAX = 200;
    localparam int TMEM_AW = 11;
    localparam logic [7:0] TMPL_MAX_B = 8'hC8;
    // timing: ctimer counts milliseconds
    localparam int CLK_HZ = 20000000;
    localparam int CTIMER_UNIT_MS = 1;
    localparam int MS_PER_S = 1000;
    // register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CTIMER = 8'h04;
    localparam logic [7:0] REG_TADDR = 8'h08;
    localparam logic [7:0] REG_TDATA = 8'h0C;
    localparam logic [7:0] REG_TLEN = 8'h10;
    localparam logic [7:0] REG_NETCMD = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;
    localparam logic [1:0] CONN_COM = 2'h0;
    localparam logic [1:0] CONN_NET = 2'h1;
    localparam logic [1:0] CONN_EPRINT = 2'h2;
    localparam logic [1:0] CMD_REG = 2'h1;
    localparam logic [1:0] CMD_UNREG = 2'h2;
    localparam logic [1:0] CMD_XGROUP = 2'h3;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_HDR = 5'b00010,
        ST_FRM = 5'b00100,
        ST_TPL = 5'b01000,
        ST_ACK = 5'b10000
    } mcf_state_t;

    typedef struct packed {
        logic run;
        logic [NUM_CH-1:0] en;
        logic [3:0] tsel;
        logic tmpl;
        logic [1:0] conn;
        logic variant2;
    } mcf_ctrl_t;

    typedef struct packed {
        logic [3:0] tnum;
        logic [7:0] addr;
    } mcf_taddr_t;

    typedef struct packed {
        logic [2:0] dp;
        logic [1:0] build;
        logic net;
        logic neg;
        logic oor;
        logic motion;
        logic kg;
        logic pwr;
        logic print;
        logic expand;
        logic [NUM_DIG-1:0][3:0] wt;
        logic [NUM_DIG-1:0][3:0] tare;
    } mcf_scale_t;

    typedef struct packed {
        logic b7;
        logic zero;
        logic one;
        logic [1:0] build;
        logic [2:0] dp;
    } mcf_swa_t;

    typedef struct packed {
        logic b7;
        logic pwr;
        logic one;
        logic kg;
        logic motion;
        logic oor;
        logic neg;
        logic net;
    } mcf_swb_t;

    typedef struct packed {
        logic b7;
        logic zero;
        logic one;
        logic expand;
        logic print;
        logic [CH_W-1:0] chan;
    } mcf_swc_t;

    typedef struct packed {
        logic ack_pend;
        logic registered;
        logic [1:0] streams;
        logic [11:0] seq;
        logic [4:0] state;
    } mcf_stat_t;
endpackage : mcf_pkg
